// ===== shared/fspc_pkg.sv
// Purpose: Constants for the flash self-program controller
// Assumes: 40 MHz core clock; flash timing from the RC oscillator
// Notes: Operation list follows
// Operation
// - Reset vector chosen by boot reset fuse
// - Software can never alter any fuse
// - Pointer from low/high bytes plus extension
// - Word bits index page, upper bits page
// - Latch target address when operation starts
// - Read instructions use Z0 byte select
// - Page erase: X0000011 then store within four
// - Stall core when target halted-read region
// - Buffer load: 00000001 stores data word
// - Buffer clears on write, reenable, reset
// - Data memory write keeps buffer intact
// - Page write: X0000101 programs buffer page
// - Level interrupt while enable bit clear
// - Block concurrent region, busy flag set
// - Busy flag held until reenable written
// - Lock program: X0001001 with R0 values
// - Program lock bits where R0 bit zero
// - Lock programming blocks no reads
// - Command bits clear after four idle cycles
// - Refuse start during data memory write
// - Program time 3.7 ms to 4.5 ms
package fspc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RC_HZ = 8000000;
  localparam int unsigned PROG_TIME_US = 4000;
  localparam int unsigned PROG_RC_TICKS = PROG_TIME_US * (RC_HZ / 1000000);
  localparam int unsigned WIN_CYCLES = 4;
  localparam int unsigned PAGE_WORD_BITS = 7;
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned WADDR_BITS = 17;
  localparam int unsigned PAGE_BITS = WADDR_BITS - PAGE_WORD_BITS;
  localparam int unsigned PAGE_WORDS = 128;
  localparam logic [WADDR_BITS-1:0] APP_RESET_WADDR = 17'h00000;
  localparam logic [WADDR_BITS-1:0] LOADER_START_WADDR = 17'h1F000;
  localparam logic [PAGE_BITS-1:0] HALTED_PAGE_FIRST = 10'h3C0;
  localparam int unsigned CSR_EN_BIT = 0;
  localparam int unsigned CSR_ERASE_BIT = 1;
  localparam int unsigned CSR_WRITE_BIT = 2;
  localparam int unsigned CSR_LOCK_BIT = 3;
  localparam int unsigned CSR_REEN_BIT = 4;
  localparam int unsigned CSR_BUSY_BIT = 6;
  localparam int unsigned CSR_IE_BIT = 7;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_LOAD = 7'h01;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_LOCK = 7'h09;
  localparam logic [6:0] CMD_REEN = 7'h11;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  localparam logic [7:0] CSR_RESET = 8'h00;
  typedef enum logic [2:0] {
    FSPC_IDLE = 3'b000,
    FSPC_ERASE = 3'b001,
    FSPC_WRITE = 3'b010,
    FSPC_LOCK = 3'b011
  } fspc_state_t;
endpackage

// ===== sim/fspc_core_model.sv
// Purpose: Core issuing command writes and store-program pulses
// Assumes: Drives on falling edges
// Notes: RC clock sped up to keep the run short
`timescale 1ns/1ps
`default_nettype none
module fspc_core_model (
  input wire logic clk_sys_in,
  output logic rc_clk_out,
  output logic csr_wr_out,
  output logic [7:0] csr_wdata_out,
  output logic spm_out
);
  initial begin
    rc_clk_out = 1'b0;
    csr_wr_out = 1'b0;
    csr_wdata_out = 8'h00;
    spm_out = 1'b0;
  end
  always @(negedge clk_sys_in) begin
    rc_clk_out <= ~rc_clk_out;
  end
  // Gap 0 writes without a store
  task automatic issue(input logic [7:0] cmd, input int gap);
    @(negedge clk_sys_in);
    csr_wr_out = 1'b1;
    csr_wdata_out = cmd;
    @(negedge clk_sys_in);
    csr_wr_out = 1'b0;
    if (gap > 0) begin
      repeat (gap - 1) @(negedge clk_sys_in);
      spm_out = 1'b1;
      @(negedge clk_sys_in);
      spm_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/fspc_ctrl_properties.sv
// Purpose: Port checks for fspc_ctrl
// Assumes: Bound to the top module
// Notes: Status bits read from csr_rdata_out
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_properties
  import fspc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic csr_wr_in,
  input wire logic [7:0] csr_wdata_in,
  input wire logic spm_in,
  input wire logic nvm_data_busy_in,
  input wire logic [7:0] csr_rdata_out,
  input wire logic concurrent_read_block_out,
  input wire logic core_stall_out,
  input wire logic spm_irq_out,
  input wire logic flash_erase_out,
  input wire logic flash_write_out,
  input wire logic [PAGE_BITS-1:0] flash_page_out,
  input wire logic lock_prog_out
);
  wire logic op_w = flash_erase_out | flash_write_out | lock_prog_out;
  logic [2:0] win_cnt;
  wire logic go_w = spm_in & ~op_w & ~nvm_data_busy_in & (win_cnt != 3'h0);
  // Store window after an accepted command write
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      win_cnt <= 3'h0;
    end else if (csr_wr_in && !op_w && !nvm_data_busy_in) begin
      win_cnt <= 3'(WIN_CYCLES);
    end else if (win_cnt != 3'h0) begin
      win_cnt <= win_cnt - 3'h1;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  AST_ERASE_GO: assert property (go_w && csr_rdata_out[4:0] == 5'h03 |=> flash_erase_out)
    else $error("erase not started");
  AST_LOCK_GO: assert property (go_w && csr_rdata_out[4:0] == 5'h09 |=> lock_prog_out)
    else $error("lock not started");
  AST_WRITE_GO: assert property (go_w && csr_rdata_out[4:0] == 5'h05 |=> flash_write_out)
    else $error("write not started");
  AST_CMD_TIMEOUT: assert property (csr_wr_in && !op_w && !nvm_data_busy_in && !csr_wdata_in[4]
    ##1 (!spm_in && !csr_wr_in)[*4] ##1 !csr_wr_in |=> !csr_rdata_out[0]) else $error("command not cleared");
  AST_BUSY_OP: assert property (flash_erase_out || flash_write_out
    |-> concurrent_read_block_out && csr_rdata_out[6]) else $error("region not blocked");
  AST_EN_HELD: assert property (op_w |-> csr_rdata_out[0])
    else $error("enable bit dropped");
  AST_IRQ: assert property ((csr_rdata_out[7] && !csr_rdata_out[0])[*2] |-> spm_irq_out)
    else $error("irq missing");
  AST_STALL: assert property (flash_erase_out && flash_page_out >= HALTED_PAGE_FIRST |-> core_stall_out)
    else $error("no stall");
  AST_LOCK_FREE: assert property (lock_prog_out |-> !core_stall_out)
    else $error("stall in lock");
  AST_REEN: assert property (csr_wr_in && csr_wdata_in[6:0] == CMD_REEN && !op_w && !nvm_data_busy_in
    |=> !concurrent_read_block_out) else $error("busy not cleared");
  cover property ($rose(flash_erase_out));
  cover property ($rose(lock_prog_out));
  cover property ($rose(flash_write_out));
  cover property ($fell(concurrent_read_block_out));
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Self-checking bench for fspc_ctrl
// Assumes: Core model issues commands
// Notes: One full erase; other operations cut by reset, and the final page write cut by the end of the run
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fspc_pkg::*;
;
  logic clk_sys_in, rstn_in, boot_in, nvm_in, rc_w, wr_w, spm_w;
  logic [7:0] wd_w;
  logic [23:0] z;
  logic [15:0] dw;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  fspc_core_model core (.clk_sys_in(clk_sys_in), .rc_clk_out(rc_w), .csr_wr_out(wr_w), .csr_wdata_out(wd_w),
    .spm_out(spm_w));
  fspc_ctrl uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .boot_reset_select_in(boot_in), .rc_clk_in(rc_w),
    .csr_wr_in(wr_w), .csr_wdata_in(wd_w), .spm_in(spm_w), .pointer_low_byte_in(z[7:0]),
    .pointer_high_byte_in(z[15:8]), .pointer_extension_byte_in(z[23:16]), .data_word_regs_in(dw),
    .nvm_data_busy_in(nvm_in), .fetch_waddr_in(17'h00000), .program_read_instr_in(1'b0), .csr_rdata_out(),
    .reset_vector_out(), .read_byte_hi_out(), .read_waddr_out(), .concurrent_read_block_out(),
    .core_stall_out(), .spm_irq_out(), .flash_erase_out(), .flash_write_out(), .flash_page_out(),
    .buf_rdata_out(), .buf_raddr_out(), .lock_prog_out(), .lock_bits_out());
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      miscompares++;
      finish_test;
    end
  end
  task automatic chk(input logic c);
    check_count++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t check %0d", $time, check_count);
    end
  endtask
  task automatic t_reset(input logic fuse);
    rstn_in = 1'b0;
    boot_in = fuse;
    repeat (20) @(negedge clk_sys_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk(uut.reset_vector_out === (fuse ? APP_RESET_WADDR : LOADER_START_WADDR));
    chk(uut.lock_bits_out === LOCK_RESET && uut.buf_rdata_out === 16'hFFFF);
  endtask
  task automatic t_window;
    core.issue(8'h03, 5);
    @(negedge clk_sys_in);
    chk(uut.flash_erase_out === 1'b0 && uut.csr_rdata_out[0] === 1'b0);
  endtask
  task automatic t_nvm;
    nvm_in = 1'b1;
    core.issue(8'h09, 2);
    @(negedge clk_sys_in);
    chk(uut.lock_prog_out === 1'b0);
    nvm_in = 1'b0;
  endtask
  task automatic t_lock;
    z = 24'h000001;
    dw = 16'h00F5;
    core.issue(8'h09, 4);
    @(negedge clk_sys_in);
    chk(uut.lock_prog_out === 1'b1);
    chk(uut.concurrent_read_block_out === 1'b0 && uut.core_stall_out === 1'b0);
  endtask
  task automatic t_halt;
    z = 24'h03C000;
    core.issue(8'h03, 1);
    @(negedge clk_sys_in);
    chk(uut.core_stall_out === 1'b1 && uut.flash_page_out === HALTED_PAGE_FIRST);
    z = 24'h000000;
    repeat (3) @(negedge clk_sys_in);
    chk(uut.flash_page_out === HALTED_PAGE_FIRST);
  endtask
  task automatic t_full;
    int n;
    z = 24'h012301;
    repeat (2) @(negedge clk_sys_in);
    chk(uut.read_byte_hi_out === 1'b1 && uut.read_waddr_out === z[17:1]);
    core.issue(8'h83, 3);
    @(negedge clk_sys_in);
    chk(uut.flash_erase_out === 1'b1 && uut.flash_page_out === 10'h123 && uut.core_stall_out === 1'b0);
    chk(uut.concurrent_read_block_out === 1'b1 && uut.csr_rdata_out[6] === 1'b1);
    chk(uut.spm_irq_out === 1'b0);
    n = 0;
    while (uut.flash_erase_out === 1'b1 && n < 80000) begin
      n++;
      @(negedge clk_sys_in);
    end
    chk(n >= 2 * PROG_RC_TICKS - 4 && n <= 2 * PROG_RC_TICKS + 8);
    repeat (2) @(negedge clk_sys_in);
    chk(uut.concurrent_read_block_out === 1'b1 && uut.csr_rdata_out[6] === 1'b1);
    chk(uut.csr_rdata_out[0] === 1'b0 && uut.spm_irq_out === 1'b1);
    core.issue(8'h11, 0);
    @(negedge clk_sys_in);
    chk(uut.concurrent_read_block_out === 1'b0 && uut.csr_rdata_out[6] === 1'b0);
    chk(uut.reset_vector_out === APP_RESET_WADDR);
    z = 24'h012302;
    dw = 16'hA55A;
    core.issue(8'h01, 2);
    @(negedge clk_sys_in);
    chk(uut.buf_rdata_out === 16'hA55A && uut.buf_raddr_out === 7'h01);
    nvm_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    nvm_in = 1'b0;
    z = 24'h012304;
    dw = 16'h3CC3;
    core.issue(8'h01, 4);
    @(negedge clk_sys_in);
    chk(uut.buf_rdata_out === 16'h3CC3 && uut.buf_raddr_out === 7'h02);
    z = 24'h012302;
    repeat (2) @(negedge clk_sys_in);
    chk(uut.buf_rdata_out === 16'hA55A);
    core.issue(8'h11, 0);
    repeat (2) @(negedge clk_sys_in);
    chk(uut.buf_rdata_out === 16'hFFFF);
    z = 24'h012300;
    dw = 16'h0F0F;
    core.issue(8'h01, 1);
    @(negedge clk_sys_in);
    chk(uut.buf_rdata_out === 16'h0F0F && uut.buf_raddr_out === 7'h00);
    core.issue(8'h05, 2);
    @(negedge clk_sys_in);
    chk(uut.flash_write_out === 1'b1 && uut.flash_page_out === 10'h123);
    chk(uut.concurrent_read_block_out === 1'b1 && uut.flash_erase_out === 1'b0);
  endtask
  initial begin
    rstn_in = 1'b0;
    boot_in = 1'b1;
    nvm_in = 1'b0;
    z = 24'h000000;
    dw = 16'h0000;
    t_reset(1'b1);
    t_window;
    t_nvm;
    t_lock;
    t_reset(1'b0);
    t_halt;
    t_reset(1'b1);
    t_full;
    finish_test;
  end
endmodule
bind fspc_ctrl fspc_ctrl_properties u_props (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .csr_wr_in(csr_wr_in),
  .csr_wdata_in(csr_wdata_in), .spm_in(spm_in), .nvm_data_busy_in(nvm_data_busy_in), .csr_rdata_out(csr_rdata_out),
  .concurrent_read_block_out(concurrent_read_block_out), .core_stall_out(core_stall_out),
  .spm_irq_out(spm_irq_out), .flash_erase_out(flash_erase_out), .flash_write_out(flash_write_out),
  .flash_page_out(flash_page_out), .lock_prog_out(lock_prog_out));
`default_nettype wire

// ===== src/fspc_ctrl.sv
// Purpose: Flash self-program sequencer for the core's store-program path
// Assumes: Core drives CSR writes and store-program strobes on clk_sys_in
// Notes: Fuses are read-only inputs; flash array is outside this block
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl
  import fspc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic boot_reset_select_in,
  input wire logic rc_clk_in,
  input wire logic csr_wr_in,
  input wire logic [7:0] csr_wdata_in,
  input wire logic spm_in,
  input wire logic [7:0] pointer_low_byte_in,
  input wire logic [7:0] pointer_high_byte_in,
  input wire logic [7:0] pointer_extension_byte_in,
  input wire logic [15:0] data_word_regs_in,
  input wire logic nvm_data_busy_in,
  input wire logic [WADDR_BITS-1:0] fetch_waddr_in,
  input wire logic program_read_instr_in,
  output logic [7:0] csr_rdata_out,
  output logic [WADDR_BITS-1:0] reset_vector_out,
  output logic read_byte_hi_out,
  output logic [WADDR_BITS-1:0] read_waddr_out,
  output logic concurrent_read_block_out,
  output logic core_stall_out,
  output logic spm_irq_out,
  output logic flash_erase_out,
  output logic flash_write_out,
  output logic [PAGE_BITS-1:0] flash_page_out,
  output logic [15:0] buf_rdata_out,
  output logic [6:0] buf_raddr_out,
  output logic lock_prog_out,
  output logic [5:0] lock_bits_out
);
  typedef struct packed {
    logic [1:0] fuse_sync;
    logic [2:0] rc_sync;
    logic [2:0] fuse_caught;
    logic [WADDR_BITS-1:0] reset_vector;
    logic [6:0] cmd;
    logic ie;
    logic [2:0] win;
    fspc_state_t state;
    logic start;
    logic [PAGE_BITS-1:0] page;
    logic halted_tgt;
    logic busy;
    logic block;
    logic stall;
    logic irq;
    logic erase;
    logic write;
    logic lock;
    logic [5:0] lock_bits;
    logic [5:0] lock_val;
    logic [6:0] raddr;
    logic [15:0] rdata;
    logic byte_hi;
    logic [WADDR_BITS-1:0] read_waddr;
    logic [PAGE_WORDS-1:0] loaded;
  } fspc_q_t;

  fspc_q_t q;
  fspc_q_t next_q;
  logic [15:0] page_buf [PAGE_WORDS];
  logic [ADDR_BITS-1:0] zptr;
  logic [WADDR_BITS-1:0] zword;
  logic [6:0] zidx;
  logic [PAGE_BITS-1:0] zpage;
  logic spm_take;
  logic buf_we;
  logic buf_clr;
  logic rc_tick;
  logic tmr_done;

  assign zptr = {pointer_extension_byte_in, pointer_high_byte_in, pointer_low_byte_in};
  assign zword = zptr[WADDR_BITS:1];
  assign zidx = zword[PAGE_WORD_BITS-1:0];
  assign zpage = zword[WADDR_BITS-1:PAGE_WORD_BITS];
  // Command counts only if armed, in window, and no data memory write
  assign spm_take = spm_in && q.cmd[0] && (q.win != 3'h0) &&
                    (q.state == FSPC_IDLE) && !nvm_data_busy_in;
  assign buf_we = spm_take && (q.cmd == CMD_LOAD) && !q.loaded[zidx];
  assign rc_tick = q.rc_sync[1] && !q.rc_sync[2];
  assign buf_clr = (q.state == FSPC_WRITE && tmr_done) ||
                   (csr_wr_in && csr_wdata_in[CSR_REEN_BIT] && csr_wdata_in[CSR_EN_BIT] &&
                    q.state == FSPC_IDLE);

  fspc_rc_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .start_in(q.start),
    .rc_tick_in(rc_tick),
    .done_out(tmr_done)
  );

  always_comb begin
    next_q = q;
    next_q.start = 1'b0;
    next_q.fuse_sync = {q.fuse_sync[0], boot_reset_select_in};
    next_q.rc_sync = {q.rc_sync[1:0], rc_clk_in};
    // Fuse caught once, after it has crossed both sync stages; nothing here can write it
    next_q.fuse_caught = {q.fuse_caught[1:0], 1'b1};
    if (q.fuse_caught[1] && !q.fuse_caught[2]) begin
      next_q.reset_vector = q.fuse_sync[1] ? APP_RESET_WADDR : LOADER_START_WADDR;
    end
    if (q.win != 3'h0) begin
      next_q.win = q.win - 3'h1;
    end else if (q.state == FSPC_IDLE) begin
      next_q.cmd = 7'h00;
    end
    if (csr_wr_in && q.state == FSPC_IDLE) begin
      next_q.ie = csr_wdata_in[CSR_IE_BIT];
      if (!nvm_data_busy_in) begin
        next_q.cmd = csr_wdata_in[6:0];
        next_q.win = 3'(WIN_CYCLES);
        if (csr_wdata_in[CSR_REEN_BIT] && csr_wdata_in[CSR_EN_BIT]) begin
          next_q.busy = 1'b0;
          next_q.block = 1'b0;
          next_q.cmd = 7'h00;
          next_q.win = 3'h0;
        end
      end
    end
    if (spm_take) begin
      next_q.win = 3'h0;
      next_q.cmd = 7'h00;
      next_q.page = zpage;
      next_q.halted_tgt = (zpage >= HALTED_PAGE_FIRST);
      case (q.cmd)
        CMD_ERASE, CMD_WRITE: begin
          next_q.cmd = q.cmd;
          next_q.state = (q.cmd == CMD_ERASE) ? FSPC_ERASE : FSPC_WRITE;
          next_q.start = 1'b1;
          next_q.busy = 1'b1;
          next_q.block = 1'b1;
          next_q.stall = (zpage >= HALTED_PAGE_FIRST);
          next_q.erase = (q.cmd == CMD_ERASE);
          next_q.write = (q.cmd == CMD_WRITE);
        end
        CMD_LOCK: begin
          next_q.cmd = q.cmd;
          next_q.state = FSPC_LOCK;
          next_q.start = 1'b1;
          next_q.lock = 1'b1;
          next_q.lock_val = q.lock_bits & data_word_regs_in[5:0];
        end
        CMD_LOAD: begin
          next_q.loaded[zidx] = 1'b1;
        end
        default: begin
          next_q.cmd = 7'h00;
        end
      endcase
    end
    case (q.state)
      FSPC_ERASE, FSPC_WRITE: begin
        if (tmr_done) begin
          next_q.state = FSPC_IDLE;
          next_q.cmd = 7'h00;
          next_q.erase = 1'b0;
          next_q.write = 1'b0;
          next_q.stall = 1'b0;
        end
      end
      FSPC_LOCK: begin
        if (tmr_done) begin
          next_q.state = FSPC_IDLE;
          next_q.cmd = 7'h00;
          next_q.lock = 1'b0;
          next_q.lock_bits = q.lock_val;
        end
      end
      FSPC_IDLE: begin
      end
      default: begin
        next_q.state = FSPC_IDLE;
      end
    endcase
    if (buf_clr) begin
      next_q.loaded = '0;
      // A load in the same cycle as a clear still counts
      if (buf_we) begin
        next_q.loaded[zidx] = 1'b1;
      end
    end
    next_q.irq = q.ie && !next_q.cmd[0];
    next_q.byte_hi = zptr[0];
    next_q.read_waddr = zword;
    next_q.raddr = zidx;
    next_q.rdata = q.loaded[zidx] ? page_buf[zidx] : 16'hFFFF;
  end

  // Buffer words survive data memory writes; only valid bits reset
  always_ff @(posedge clk_sys_in) begin
    if (buf_we) begin
      page_buf[zidx] <= data_word_regs_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.lock_bits <= LOCK_RESET;
      q.lock_val <= LOCK_RESET;
      q.state <= FSPC_IDLE;
      q.fuse_sync <= 2'b11;
      q.reset_vector <= APP_RESET_WADDR;
      q.rdata <= 16'hFFFF;
    end else begin
      q <= next_q;
    end
  end

  assign csr_rdata_out = {q.ie, q.busy, 1'b0, q.cmd[4:0]} | CSR_RESET;
  assign reset_vector_out = q.reset_vector;
  assign read_byte_hi_out = q.byte_hi;
  assign read_waddr_out = q.read_waddr;
  assign concurrent_read_block_out = q.block;
  assign core_stall_out = q.stall;
  assign spm_irq_out = q.irq;
  assign flash_erase_out = q.erase;
  assign flash_write_out = q.write;
  assign flash_page_out = q.page;
  assign buf_rdata_out = q.rdata;
  assign buf_raddr_out = q.raddr;
  assign lock_prog_out = q.lock;
  assign lock_bits_out = q.lock_bits;
endmodule
`default_nettype wire

// ===== src/fspc_rc_timer.sv
// Purpose: Times flash program pulses from the RC oscillator tick
// Assumes: rc_tick_in is a synchronised single-cycle pulse
// Notes: Done pulses one cycle after the last tick
`timescale 1ns/1ps
`default_nettype none
module fspc_rc_timer
  import fspc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic rc_tick_in,
  output logic done_out
);
  typedef struct packed {
    logic run;
    logic [15:0] cnt;
    logic done;
  } fspc_tmr_t;
  fspc_tmr_t q;
  fspc_tmr_t next_q;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (start_in) begin
      next_q.run = 1'b1;
      next_q.cnt = 16'h0000;
    end else if (q.run && rc_tick_in) begin
      // Count RC ticks over the program time
      if (q.cnt == 16'(PROG_RC_TICKS - 1)) begin
        next_q.run = 1'b0;
        next_q.done = 1'b1;
      end else begin
        next_q.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done_out = q.done;
endmodule
`default_nettype wire
